// ===== rtl/cbag_defines.vh
// cbag_defines.vh: register offsets, field positions, reset values and mode codes
// for the circular / bit-reversed / program-window address unit.
// assumes inclusion by bare name from the rtl/ design files.
`ifndef CBAG_DEFINES_VH
`define CBAG_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CBAG_OFF_MODE_CTRL    12'h000
`define CBAG_OFF_BITREV_CTRL  12'h004
`define CBAG_OFF_TABLE_PAGE   12'h008
`define CBAG_OFF_WINDOW_PAGE  12'h00C
`define CBAG_OFF_CORE_CTRL    12'h010
`define CBAG_OFF_X_START      12'h014
`define CBAG_OFF_X_END        12'h018
`define CBAG_OFF_Y_START      12'h01C
`define CBAG_OFF_Y_END        12'h020
`define CBAG_OFF_STATUS       12'h024

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CBAG_XSEL_LSB         0
`define CBAG_YSEL_LSB         4
`define CBAG_BRSEL_LSB        8
`define CBAG_YEN_BIT          14
`define CBAG_XEN_BIT          15
`define CBAG_BITREV_ENABLE_BIT         15
`define CBAG_WINEN_BIT        2
`define CBAG_PAGE_CFG_BIT     7
`define CBAG_SEL_OFF          4'hF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CBAG_RST_MODE_CTRL    16'h0FFF
`define CBAG_RST_BITREV       16'h0000
`define CBAG_RST_PAGE         8'h00
`define CBAG_RST_WORD         16'h0000

// ---------------------------------------------------------------
// addressing modes
// ---------------------------------------------------------------
`define CBAG_AM_IND           3'h0
`define CBAG_AM_POST_INC      3'h1
`define CBAG_AM_POST_DEC      3'h2
`define CBAG_AM_PRE_INC       3'h3
`define CBAG_AM_PRE_DEC       3'h4
`define CBAG_AM_OFFSET        3'h5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CBAG_WINDOW_EXTRA     1

`endif

// ===== rtl/cbag_circ.v
// cbag_circ.v: one circular-buffer correction lane with boundary wrap.
// assumes start/end are inclusive byte bounds and a step smaller than the length.
`timescale 1ns/1ps
`default_nettype none
module cbag_circ #(
    parameter AW = 16
) (
    // operands
    input  wire [AW-1:0] addr_i,
    input  wire [AW-1:0] start_i,
    input  wire [AW-1:0] end_i,
    input  wire          up_i,
    input  wire          en_i,
    // result
    output reg  [AW-1:0] addr_o,
    output reg           wrap_o
);
    reg [AW-1:0] len;

    // compare against the bound and wrap by the length, keeping overshoot
    always @* begin
        len    = end_i - start_i + {{(AW-1){1'b0}}, 1'b1};
        addr_o = addr_i;
        wrap_o = 1'b0;
        if (en_i && up_i && (addr_i > end_i)) begin
            addr_o = addr_i - len;
            wrap_o = 1'b1;
        end else if (en_i && !up_i && (addr_i < start_i)) begin
            addr_o = addr_i + len;
            wrap_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/cbag_top.v
// cbag_top.v: data address generation with modulo wrap, bit-reversed writes
// and program-space address forming, plus its AHB-Lite register slave.
// assumes AHB-Lite single word transfers and pipeline operands valid per request.
//
// Functional notes
// - any working register may be circular pointer; here select 15 means off, so register 15 cannot be one
// - detect crossing only beyond bounds, not at them
// - write back only for pre/post modify
// - bit reversal only X unit writes
// - modifier is reversed, addresses stay normal
// - enable needs select not 15, enable, increment
// - hold fifteen-bit bit-reverse modifier
// - word addresses, modifier scaled to bytes
// - other modes or bytes use normal addresses
// - pointer plus modifier, offset ignored, lsb zero
// - bit reversal beats circular in X writes
// - four address bits mirror in sequence; the code mirrors all fifteen word-address bits
// - table address is page over data address
// - page bit 7 selects configuration space
// - window address is page over fifteen bits
// - window is read-only, low word only
// - table reaches every byte including upper
// - X circular needs select not 15, enable
// - Y circular needs select not 15, enable
// - window reads need enable, add one cycle
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cbag_defines.vh"
module cbag_top #(
    parameter AW = 16
) (
    // clock and reset
    input  wire          MCLK_I,
    input  wire          RST_N_I,
    // ahb-lite slave
    input  wire          HSEL_I,
    input  wire [11:0]   HADDR_I,
    input  wire [1:0]    HTRANS_I,
    input  wire          HWRITE_I,
    input  wire [2:0]    HSIZE_I,
    input  wire [31:0]   HWDATA_I,
    input  wire          HREADY_I,
    output reg  [31:0]   HRDATA_O,
    output reg           HREADYOUT_O,
    output reg           HRESP_O,
    // pipeline request
    input  wire          REQ_VALID_I,
    input  wire          REQ_X_I,
    input  wire          REQ_WRITE_I,
    input  wire          REQ_BYTE_I,
    input  wire          REQ_TABLE_I,
    input  wire          REQ_TABLE_HIGH_I,
    input  wire [2:0]    REQ_MODE_I,
    input  wire [3:0]    REQ_REG_I,
    input  wire [AW-1:0] REQ_PTR_I,
    input  wire [AW-1:0] REQ_OFFSET_I,
    // generated addresses
    output reg           EA_VALID_O,
    output reg  [AW-1:0] EA_O,
    output reg           WB_EN_O,
    output reg  [3:0]    WB_REG_O,
    output reg  [AW-1:0] WB_VALUE_O,
    output reg           PROG_EN_O,
    output reg  [23:0]   PROG_ADDR_O,
    output reg           PROG_CFG_O,
    output reg           PROG_HIGH_O,
    output reg           PROG_WRITE_O,
    output reg           DATA_EN_O,
    output reg           STALL_O,
    output reg           ERR_O
);
    // -----------------------------------------------------------
    // registers
    // -----------------------------------------------------------
    reg [15:0] mode_ctrl_reg;
    reg [15:0] bit_reverse_control_reg;
    reg [7:0]  table_page_reg;
    reg [7:0]  program_window_page_reg;
    reg [15:0] core_control_reg;
    reg [15:0] x_start_reg;
    reg [15:0] x_end_reg;
    reg [15:0] y_start_reg;
    reg [15:0] y_end_reg;
    reg [15:0] wrap_count_reg;
    reg        last_wrap_reg;
    reg        last_bitrev_reg;
    reg        wr_pend_reg;
    reg [11:0] wr_addr_reg;

    wire [3:0] x_circular_pointer_select = mode_ctrl_reg[`CBAG_XSEL_LSB +: 4];
    wire [3:0] y_circular_pointer_select = mode_ctrl_reg[`CBAG_YSEL_LSB +: 4];
    wire [3:0] bitrev_pointer_select     = mode_ctrl_reg[`CBAG_BRSEL_LSB +: 4];
    wire       x_circular_enable         = mode_ctrl_reg[`CBAG_XEN_BIT];
    wire       y_circular_enable         = mode_ctrl_reg[`CBAG_YEN_BIT];
    wire       bitrev_enable             = bit_reverse_control_reg[`CBAG_BITREV_ENABLE_BIT];
    wire [14:0] bitrev_modifier          = bit_reverse_control_reg[14:0];
    wire       program_window_enable     = core_control_reg[`CBAG_WINEN_BIT];

    // -----------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------
    wire m_inc   = (REQ_MODE_I == `CBAG_AM_POST_INC) || (REQ_MODE_I == `CBAG_AM_PRE_INC);
    wire m_dec   = (REQ_MODE_I == `CBAG_AM_POST_DEC) || (REQ_MODE_I == `CBAG_AM_PRE_DEC);
    wire m_pre   = (REQ_MODE_I == `CBAG_AM_PRE_INC)  || (REQ_MODE_I == `CBAG_AM_PRE_DEC);
    wire m_mod   = m_inc || m_dec;
    wire m_off   = (REQ_MODE_I == `CBAG_AM_OFFSET);

    // bit reversal is X write word access, increment modes, pointer selected
    wire br_on = bitrev_enable && (bitrev_pointer_select != `CBAG_SEL_OFF)
               && (REQ_REG_I == bitrev_pointer_select) && m_inc
               && REQ_X_I && REQ_WRITE_I
               && !REQ_BYTE_I && !REQ_TABLE_I;

    // circular enables per space, any working register but 15 may be chosen
    wire x_circ = x_circular_enable && (x_circular_pointer_select != `CBAG_SEL_OFF)
                && (REQ_REG_I == x_circular_pointer_select);
    wire y_circ = y_circular_enable && (y_circular_pointer_select != `CBAG_SEL_OFF)
                && (REQ_REG_I == y_circular_pointer_select);
    wire circ_en = (REQ_X_I ? x_circ : y_circ) && !br_on;

    // -----------------------------------------------------------
    // address arithmetic
    // -----------------------------------------------------------
    reg  [AW-1:0] step;
    reg  [AW-1:0] mod_addr;
    reg  [15:0]   rev_mod;
    reg  [15:0]   ptr_rev;
    reg  [15:0]   rev_sum;
    integer       k;

    // reversed-carry add: mirror pointer word bits, add mirrored modifier, mirror back
    always @* begin
        rev_mod = 16'h0000;
        ptr_rev = 16'h0000;
        rev_sum = 16'h0000;
        step    = m_dec ? (~REQ_OFFSET_I + {{(AW-1){1'b0}}, 1'b1}) : REQ_OFFSET_I;
        for (k = 0; k < 15; k = k + 1) begin
            rev_mod[14-k] = bitrev_modifier[k];
            ptr_rev[14-k] = REQ_PTR_I[k+1];
        end
        rev_sum = ptr_rev + rev_mod;
        mod_addr = REQ_PTR_I + step;
        for (k = 0; k < 15; k = k + 1) begin
            if (br_on) begin
                mod_addr[k+1] = rev_sum[14-k];
            end
        end
        if (br_on) begin
            mod_addr[0] = 1'b0;
        end
    end

    wire [AW-1:0] circ_in = m_off ? (REQ_PTR_I + REQ_OFFSET_I) : mod_addr;
    wire [AW-1:0] cstart  = REQ_X_I ? x_start_reg : y_start_reg;
    wire [AW-1:0] cend    = REQ_X_I ? x_end_reg : y_end_reg;
    wire          cup     = !m_dec;
    wire [AW-1:0] circ_out;
    wire          circ_wrap;

    // circular correction lane
    cbag_circ #(
        .AW     (AW)
    ) u_circ (
        .addr_i (circ_in),
        .start_i(cstart),
        .end_i  (cend),
        .up_i   (cup),
        .en_i   (circ_en && (m_mod || m_off)),
        .addr_o (circ_out),
        .wrap_o (circ_wrap)
    );

    wire [AW-1:0] new_ptr = br_on ? mod_addr : circ_out;
    wire [AW-1:0] ea_next = (m_pre || m_off) ? new_ptr : REQ_PTR_I;

    // program-space routing
    wire win_hit   = !REQ_TABLE_I && ea_next[AW-1] && program_window_enable;
    wire win_write = win_hit && REQ_WRITE_I;

    // -----------------------------------------------------------
    // address outputs
    // -----------------------------------------------------------
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            EA_VALID_O   <= 1'b0;
            EA_O         <= {AW{1'b0}};
            WB_EN_O      <= 1'b0;
            WB_REG_O     <= 4'h0;
            WB_VALUE_O   <= {AW{1'b0}};
            PROG_EN_O    <= 1'b0;
            PROG_ADDR_O  <= 24'h000000;
            PROG_CFG_O   <= 1'b0;
            PROG_HIGH_O  <= 1'b0;
            PROG_WRITE_O <= 1'b0;
            DATA_EN_O    <= 1'b0;
            STALL_O      <= 1'b0;
            ERR_O        <= 1'b0;
        end else begin
            EA_VALID_O   <= REQ_VALID_I;
            EA_O         <= ea_next;
            WB_EN_O      <= REQ_VALID_I && m_mod;
            WB_REG_O     <= REQ_REG_I;
            WB_VALUE_O   <= new_ptr;
            PROG_EN_O    <= REQ_VALID_I && (REQ_TABLE_I || (win_hit && !REQ_WRITE_I));
            PROG_WRITE_O <= REQ_VALID_I && REQ_TABLE_I && REQ_WRITE_I;
            PROG_HIGH_O  <= REQ_VALID_I && REQ_TABLE_I && REQ_TABLE_HIGH_I;
            DATA_EN_O    <= REQ_VALID_I && !REQ_TABLE_I && !win_hit;
            ERR_O        <= REQ_VALID_I && win_write;
            STALL_O      <= REQ_VALID_I && win_hit && !REQ_WRITE_I;
            if (REQ_TABLE_I) begin
                PROG_ADDR_O <= {table_page_reg, ea_next};
                PROG_CFG_O  <= table_page_reg[`CBAG_PAGE_CFG_BIT];
            end else begin
                PROG_ADDR_O <= {1'b0, program_window_page_reg, ea_next[14:0]};
                PROG_CFG_O  <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------
    // status capture
    // -----------------------------------------------------------
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wrap_count_reg  <= `CBAG_RST_WORD;
            last_wrap_reg   <= 1'b0;
            last_bitrev_reg <= 1'b0;
        end else if (REQ_VALID_I) begin
            last_wrap_reg   <= circ_wrap;
            last_bitrev_reg <= br_on;
            if (circ_wrap) begin
                wrap_count_reg <= wrap_count_reg + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------
    // ahb-lite slave
    // -----------------------------------------------------------
    wire ahb_go = HSEL_I && HREADY_I && HTRANS_I[1];
    reg [31:0] rd_mux;

    // read decode, unmapped reads zero
    always @* begin
        rd_mux = 32'h00000000;
        case (HADDR_I)
            `CBAG_OFF_MODE_CTRL:   rd_mux = {16'h0000, mode_ctrl_reg};
            `CBAG_OFF_BITREV_CTRL: rd_mux = {16'h0000, bit_reverse_control_reg};
            `CBAG_OFF_TABLE_PAGE:  rd_mux = {24'h000000, table_page_reg};
            `CBAG_OFF_WINDOW_PAGE: rd_mux = {24'h000000, program_window_page_reg};
            `CBAG_OFF_CORE_CTRL:   rd_mux = {16'h0000, core_control_reg};
            `CBAG_OFF_X_START:     rd_mux = {16'h0000, x_start_reg};
            `CBAG_OFF_X_END:       rd_mux = {16'h0000, x_end_reg};
            `CBAG_OFF_Y_START:     rd_mux = {16'h0000, y_start_reg};
            `CBAG_OFF_Y_END:       rd_mux = {16'h0000, y_end_reg};
            `CBAG_OFF_STATUS:      rd_mux = {14'h0000, last_bitrev_reg, last_wrap_reg,
                                             wrap_count_reg};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    // address phase capture, read data and write commit
    always @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            HRDATA_O                <= 32'h00000000;
            HREADYOUT_O             <= 1'b1;
            HRESP_O                 <= 1'b0;
            wr_pend_reg             <= 1'b0;
            wr_addr_reg             <= 12'h000;
            mode_ctrl_reg           <= `CBAG_RST_MODE_CTRL;
            bit_reverse_control_reg <= `CBAG_RST_BITREV;
            table_page_reg          <= `CBAG_RST_PAGE;
            program_window_page_reg <= `CBAG_RST_PAGE;
            core_control_reg        <= `CBAG_RST_WORD;
            x_start_reg             <= `CBAG_RST_WORD;
            x_end_reg               <= `CBAG_RST_WORD;
            y_start_reg             <= `CBAG_RST_WORD;
            y_end_reg               <= `CBAG_RST_WORD;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_pend_reg <= ahb_go && HWRITE_I;
            wr_addr_reg <= HADDR_I;
            if (ahb_go && !HWRITE_I) begin
                HRDATA_O <= rd_mux;
            end
            if (wr_pend_reg) begin
                case (wr_addr_reg)
                    `CBAG_OFF_MODE_CTRL:   mode_ctrl_reg           <= HWDATA_I[15:0];
                    `CBAG_OFF_BITREV_CTRL: bit_reverse_control_reg <= HWDATA_I[15:0];
                    `CBAG_OFF_TABLE_PAGE:  table_page_reg          <= HWDATA_I[7:0];
                    `CBAG_OFF_WINDOW_PAGE: program_window_page_reg <= HWDATA_I[7:0];
                    `CBAG_OFF_CORE_CTRL:   core_control_reg        <= HWDATA_I[15:0];
                    `CBAG_OFF_X_START:     x_start_reg             <= HWDATA_I[15:0];
                    `CBAG_OFF_X_END:       x_end_reg               <= HWDATA_I[15:0];
                    `CBAG_OFF_Y_START:     y_start_reg             <= HWDATA_I[15:0];
                    `CBAG_OFF_Y_END:       y_end_reg               <= HWDATA_I[15:0];
                    default:               wr_pend_reg             <= 1'b0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/cbag_pipe_model.sv
// cbag_pipe_model.sv: cpu pipeline model that issues address requests
// assumes the bench calls issue at most once per clock edge
`timescale 1ns/1ps
`default_nettype none
module cbag_pipe_model (
    // clock
    input  wire logic        clk_i,
    // request
    output var  logic        vld_o,
    output var  logic [7:0]  ctl_o,
    output var  logic [3:0]  reg_o,
    output var  logic [15:0] ptr_o,
    output var  logic [15:0] off_o
);
    // --------
    // driver
    // --------
    // quiet request lines at time zero
    initial begin
        vld_o = 1'b0;
        ctl_o = 8'h00;
        reg_o = 4'h0;
        ptr_o = 16'h0000;
        off_o = 16'h0000;
    end
    // one request per edge, ctl is {x, write, byte, table, high, mode}
    task automatic issue(input logic [7:0] c, input logic [3:0] g, input logic [15:0] p, o);
        @(posedge clk_i);
        vld_o <= 1'b1;
        ctl_o <= c;
        reg_o <= g;
        ptr_o <= p;
        off_o <= o;
    endtask
    // drop the request, scramble pointer and offset so stale values never help
    task automatic idle();
        @(posedge clk_i);
        vld_o <= 1'b0;
        ptr_o <= ~ptr_o;
        off_o <= ~off_o;
    endtask
endmodule
`default_nettype wire

// ===== verification/cbag_top_chk.sv
// cbag_top_chk.sv: concurrent checks on the address unit ports
// assumes binding to cbag_top with its AW parameter
`timescale 1ns/1ps
`default_nettype none
`include "cbag_defines.vh"
module cbag_top_chk #(
    parameter AW = 16
) (
    // clock and reset
    input wire logic          MCLK_I,
    input wire logic          RST_N_I,
    // watched ports
    input wire logic          HRESP_O,
    input wire logic          HREADYOUT_O,
    input wire logic          REQ_VALID_I,
    input wire logic          REQ_WRITE_I,
    input wire logic          REQ_TABLE_I,
    input wire logic [2:0]    REQ_MODE_I,
    input wire logic [3:0]    REQ_REG_I,
    input wire logic [AW-1:0] REQ_PTR_I,
    input wire logic          EA_VALID_O,
    input wire logic [AW-1:0] EA_O,
    input wire logic          WB_EN_O,
    input wire logic [3:0]    WB_REG_O,
    input wire logic          PROG_EN_O,
    input wire logic [23:0]   PROG_ADDR_O,
    input wire logic          PROG_CFG_O,
    input wire logic          DATA_EN_O,
    input wire logic          STALL_O,
    input wire logic          ERR_O
);
    // --------
    // checks
    // --------
    default clocking dc @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // request shapes
    sequence s_mod;
        REQ_VALID_I && REQ_MODE_I >= `CBAG_AM_POST_INC && REQ_MODE_I <= `CBAG_AM_PRE_DEC;
    endsequence
    sequence s_post;
        REQ_VALID_I && (REQ_MODE_I == `CBAG_AM_POST_INC || REQ_MODE_I == `CBAG_AM_POST_DEC);
    endsequence
    sequence s_win;
        REQ_VALID_I && !REQ_TABLE_I && REQ_PTR_I[15] && REQ_MODE_I == `CBAG_AM_IND;
    endsequence
    okay_resp_a: assert property (HRESP_O == 1'b0)
        else $error("bus response not okay");
    ready_high_a: assert property (HREADYOUT_O == 1'b1)
        else $error("bus slave inserted wait");
    quiet_idle_a: assert property (!REQ_VALID_I |=> !(EA_VALID_O || WB_EN_O || PROG_EN_O
        || DATA_EN_O || STALL_O || ERR_O)) else $error("output pulse without request");
    one_target_a: assert property (REQ_VALID_I |=> EA_VALID_O
        && $onehot({DATA_EN_O, PROG_EN_O, ERR_O})) else $error("request target not unique");
    wb_mod_a: assert property (s_mod |=> WB_EN_O && WB_REG_O == $past(REQ_REG_I))
        else $error("modify mode without write back");
    offset_keep_a: assert property (REQ_VALID_I && REQ_MODE_I == `CBAG_AM_OFFSET |=> !WB_EN_O)
        else $error("offset mode wrote pointer");
    post_ea_a: assert property (s_post |=> EA_O == $past(REQ_PTR_I))
        else $error("post modify address not old pointer");
    table_addr_a: assert property (REQ_VALID_I && REQ_TABLE_I |=> PROG_EN_O
        && PROG_ADDR_O[15:0] == EA_O && PROG_CFG_O == PROG_ADDR_O[23]) else $error("table address");
    window_addr_a: assert property ((s_win and !REQ_WRITE_I) |=> PROG_EN_O |-> STALL_O
        && !PROG_CFG_O && !PROG_ADDR_O[23] && PROG_ADDR_O[14:0] == EA_O[14:0])
        else $error("window address");
    window_ro_a: assert property ((s_win and REQ_WRITE_I) |=> !PROG_EN_O)
        else $error("window write reached program space");
    stall_cause_a: assert property (STALL_O |-> PROG_EN_O && !$past(REQ_TABLE_I))
        else $error("stall without window read");
endmodule
bind cbag_top cbag_top_chk #(.AW(AW)) u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .HRESP_O(HRESP_O), .HREADYOUT_O(HREADYOUT_O), .REQ_VALID_I(REQ_VALID_I),
    .REQ_WRITE_I(REQ_WRITE_I), .REQ_TABLE_I(REQ_TABLE_I), .REQ_MODE_I(REQ_MODE_I),
    .REQ_REG_I(REQ_REG_I), .REQ_PTR_I(REQ_PTR_I), .EA_VALID_O(EA_VALID_O), .EA_O(EA_O),
    .WB_EN_O(WB_EN_O), .WB_REG_O(WB_REG_O), .PROG_EN_O(PROG_EN_O), .PROG_ADDR_O(PROG_ADDR_O),
    .PROG_CFG_O(PROG_CFG_O), .DATA_EN_O(DATA_EN_O), .STALL_O(STALL_O), .ERR_O(ERR_O));
`default_nettype wire

// ===== verification/cbag_top_tb.sv
// cbag_top_tb.sv: self-checking bench for the address unit and its registers
// assumes cbag_defines.vh on the include path and a zero-wait ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "cbag_defines.vh"
module cbag_top_tb;
    typedef struct {logic [63:0] v; logic [63:0] m;} exp_t;
    localparam logic [7:0] XW = 8'hC0, XR = 8'h80;
    localparam logic [3:0] D = 4'b0100, P = 4'b1000;
    logic clk, rst_n, hsel, hwrite, hrdy, hresp, eav, wbe, pe, cfg, phi, pw, de, st, er, vld;
    logic [1:0] htrans;
    logic [3:0] wbr, rg;
    logic [7:0] ctl;
    logic [11:0] haddr;
    logic [15:0] ea, wbv, ptr, off, r;
    logic [15:0] br [5];
    logic [23:0] pa;
    logic [31:0] hwdata, hrdata;
    exp_t q[$];
    exp_t cur;
    int fail_count, n_tests, cyc, i;
    // --------
    // harness
    // --------
    cbag_top dut (.MCLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .REQ_VALID_I(vld),
        .REQ_X_I(ctl[7]), .REQ_WRITE_I(ctl[6]), .REQ_BYTE_I(ctl[5]), .REQ_TABLE_I(ctl[4]),
        .REQ_TABLE_HIGH_I(ctl[3]), .REQ_MODE_I(ctl[2:0]), .REQ_REG_I(rg), .REQ_PTR_I(ptr),
        .REQ_OFFSET_I(off), .EA_VALID_O(eav), .EA_O(ea), .WB_EN_O(wbe), .WB_REG_O(wbr),
        .WB_VALUE_O(wbv), .PROG_EN_O(pe), .PROG_ADDR_O(pa), .PROG_CFG_O(cfg), .PROG_HIGH_O(phi),
        .PROG_WRITE_O(pw), .DATA_EN_O(de), .STALL_O(st), .ERR_O(er));
    cbag_pipe_model pm (.clk_i(clk), .vld_o(vld), .ctl_o(ctl), .reg_o(rg), .ptr_o(ptr),
        .off_o(off));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // shared compare
    task automatic chk(input logic [63:0] g, e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // verdict and end of run
    task automatic complete_run();
        if (q.size() != 0) fail_count++;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // single ahb-lite word transfer, read data checked at the data phase end
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : ~d;
        do @(posedge clk); while (hrdy !== 1'b1);
        if (!w) chk({32'h0, hrdata}, {32'h0, d});
        hsel <= 1'b0;
    endtask
    // note the expected outcome, then issue the request
    task automatic ex(input logic [7:0] c, input logic [3:0] g, input logic [15:0] p, o, e, w,
        input logic [26:0] pr, input logic [3:0] f);
        exp_t n;
        logic wb;
        wb = (c[2:0] != `CBAG_AM_IND) && (c[2:0] != `CBAG_AM_OFFSET);
        n.v = {e, wb, w, f[3], pr, f[2:0]};
        n.m = {17'h1FFFF, {16{wb}}, 1'b1, {27{f[3]}}, 3'h7};
        q.push_back(n);
        pm.issue(c, g, p, o);
    endtask
    // monitor: oldest note against each answer
    always @(negedge clk) begin
        if (eav === 1'b1) begin
            if (q.size() == 0) chk(64'h0, 64'h1);
            else begin
                cur = q.pop_front();
                chk({ea, wbe, wbv, pe, cfg, phi, pw, pa, de, st, er} & cur.m, cur.v & cur.m);
            end
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    // --------
    // main sequence
    // --------
    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, fail_count, n_tests, cyc} = '0;
        r = $urandom(32'h30BE0A7A);
        br = '{16'h2000, 16'h2010, 16'h2008, 16'h2018, 16'h2004};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `CBAG_OFF_MODE_CTRL, {16'h0, `CBAG_RST_MODE_CTRL});
        bus(0, `CBAG_OFF_BITREV_CTRL, 32'h0);
        bus(0, 12'h030, 32'h0);
        bus(1, `CBAG_OFF_MODE_CTRL, 32'hC421);
        bus(1, `CBAG_OFF_X_START, 32'h1100);
        bus(1, `CBAG_OFF_X_END, 32'h1163);
        bus(1, `CBAG_OFF_Y_START, 32'h0800);
        bus(1, `CBAG_OFF_Y_END, 32'h081F);
        ex(XW | 1, 1, 16'h1162, 2, 16'h1162, 16'h1100, 0, D);
        ex(XR | 3, 1, 16'h1162, 4, 16'h1102, 16'h1102, 0, D);
        ex(XW | 5, 1, 16'h1160, 6, 16'h1102, 0, 0, D);
        ex(XR | 2, 1, 16'h1100, 2, 16'h1100, 16'h1162, 0, D);
        ex(XR | 1, 2, 16'h1162, 2, 16'h1162, 16'h1164, 0, D);
        ex(8'h03, 2, 16'h081E, 2, 16'h0800, 16'h0800, 0, D);
        pm.idle();
        bus(1, `CBAG_OFF_MODE_CTRL, 32'h4421);
        ex(XW | 1, 1, 16'h1162, 2, 16'h1162, 16'h1164, 0, D);
        pm.idle();
        // pointer 4, modifier 8 words, buffer at an aligned start, no read right after
        bus(1, `CBAG_OFF_BITREV_CTRL, 32'h8008);
        for (i = 0; i < 4; i++) ex(XW | 1, 4, br[i], 2, br[i], br[i+1], 0, D);
        ex(XW | 3, 4, 16'h2000, 2, 16'h2010, 16'h2010, 0, D);
        ex(8'hE1, 4, 16'h2008, 1, 16'h2008, 16'h2009, 0, D);
        ex(XR | 1, 4, 16'h2008, 2, 16'h2008, 16'h200A, 0, D);
        ex(XW | 5, 4, 16'h2000, 6, 16'h2006, 0, 0, D);
        ex(XW | 1, 5, 16'h2000, 2, 16'h2000, 16'h2002, 0, D);
        ex(8'h41, 4, 16'h2000, 2, 16'h2000, 16'h2002, 0, D);
        pm.idle();
        bus(1, `CBAG_OFF_X_START, 32'h2000);
        bus(1, `CBAG_OFF_X_END, 32'h200F);
        bus(1, `CBAG_OFF_MODE_CTRL, 32'hC424);
        ex(XW | 1, 4, 16'h2008, 2, 16'h2008, 16'h2018, 0, D);
        ex(XR | 1, 4, 16'h200E, 2, 16'h200E, 16'h2000, 0, D);
        pm.idle();
        bus(1, `CBAG_OFF_CORE_CTRL, 32'h4);
        bus(1, `CBAG_OFF_WINDOW_PAGE, 32'h12);
        bus(1, `CBAG_OFF_TABLE_PAGE, 32'h85);
        bus(0, `CBAG_OFF_TABLE_PAGE, 32'h85);
        r = $urandom;
        ex(8'h90, 6, r, 0, r, 0, {3'b100, 8'h85, r}, P);
        ex(8'hD8, 6, r, 0, r, 0, {3'b111, 8'h85, r}, P);
        ex(XR, 6, 16'h9ABC, 0, 16'h9ABC, 0, {3'b000, 24'h091ABC}, 4'b1010);
        ex(XW, 6, 16'h9ABC, 0, 16'h9ABC, 0, 0, 4'b0001);
        ex(XR, 6, 16'h1ABC, 0, 16'h1ABC, 0, 0, D);
        pm.idle();
        bus(1, `CBAG_OFF_TABLE_PAGE, 32'h05);
        ex(8'h98, 6, r, 0, r, 0, {3'b010, 8'h05, r}, P);
        pm.idle();
        bus(1, `CBAG_OFF_CORE_CTRL, 32'h0);
        ex(XR, 6, 16'h9ABC, 0, 16'h9ABC, 0, 0, D);
        pm.idle();
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `CBAG_OFF_MODE_CTRL, {16'h0, `CBAG_RST_MODE_CTRL});
        complete_run();
    end
endmodule
`default_nettype wire
